/* shared/aoscl_cfg.svh */
// Purpose: Constants of the analog monitor output scaler
// Assumes: 200 MHz clock, quantities normalised so that 16384 is 100 percent
// Notes:   Offsets are byte addresses on the AHB-Lite register port
`ifndef AOSCL_CFG_SVH
`define AOSCL_CFG_SVH

// ==========================================================
// Timing
`define AOSCL_CLK_MHZ      200
`define AOSCL_STEP_US      625
`define AOSCL_STEP_CYC     (`AOSCL_STEP_US * `AOSCL_CLK_MHZ)

// ==========================================================
// Number formats
`define AOSCL_Q_W          16
`define AOSCL_Q_FULL       16384
`define AOSCL_Q_FRAC       14
`define AOSCL_NMON         28
`define AOSCL_SEL_W        5
`define AOSCL_GAIN_W       14
`define AOSCL_GAIN_MAX     10000
`define AOSCL_GAIN_RST     1000
`define AOSCL_BIAS_W       11
`define AOSCL_BIAS_MAX     1000
`define AOSCL_RECIP        16777
`define AOSCL_RECIP_W      17
`define AOSCL_RECIP_SH     24
`define AOSCL_BIAS_SH      10
`define AOSCL_Y_W          21
`define AOSCL_FILT_W       6
`define AOSCL_FILT_MAX     50
`define AOSCL_FILT_SH      4
`define AOSCL_DAC_W        12
`define AOSCL_DAC_TOP      4095
`define AOSCL_DAC_LOW      819
`define AOSCL_DAC_SPAN     (`AOSCL_DAC_TOP - `AOSCL_DAC_LOW)

// ==========================================================
// Selection codes
`define AOSCL_CODE_BASIC_LAST  9
`define AOSCL_CODE_VEC_FIRST   10
`define AOSCL_CODE_VEC_LAST    13
`define AOSCL_CODE_VQ          17
`define AOSCL_CODE_VD          18
`define AOSCL_CODE_PID_FIRST   21
`define AOSCL_CODE_PID_LAST    25
`define AOSCL_CODE_COMM        28

// ==========================================================
// Register map
`define AOSCL_OFF_SEL1     8'h00
`define AOSCL_OFF_GAIN1    8'h04
`define AOSCL_OFF_BIAS1    8'h08
`define AOSCL_OFF_SEL2     8'h0c
`define AOSCL_OFF_GAIN2    8'h10
`define AOSCL_OFF_BIAS2    8'h14
`define AOSCL_OFF_TYPE     8'h18
`define AOSCL_OFF_FILT     8'h1c
`define AOSCL_OFF_COMM     8'h20
`define AOSCL_OFF_STAT     8'h24
`define AOSCL_OFF_OUT1     8'h28
`define AOSCL_OFF_OUT2     8'h2c
`define AOSCL_ADDR_W       8
`define AOSCL_STAT_OK_LSB  8
`define AOSCL_OUT_CUR_BIT  16
`define AOSCL_HSIZE_WORD   3'h2
`define AOSCL_HRESP_OKAY   1'h0

`endif

/* shared/aoscl_pkg.sv */
// Purpose: Types shared by the analog monitor output scaler
// Assumes: aoscl_cfg.svh gives all widths and code limits
// Notes:   Code validity lives here since both channels decode it
`include "aoscl_cfg.svh"
package aoscl_pkg;

	typedef logic signed [`AOSCL_Q_W-1:0] aoscl_q_t;
	typedef logic signed [`AOSCL_Y_W-1:0] aoscl_y_t;
	typedef aoscl_q_t [`AOSCL_NMON-1:0] aoscl_mon_t;

	typedef enum logic [1:0] {
		AOSCL_MODE_VPH = 2'b00,
		AOSCL_MODE_SLV = 2'b01,
		AOSCL_MODE_PM  = 2'b10,
		AOSCL_MODE_RSV = 2'b11
	} aoscl_mode_e;

	typedef struct packed {
		logic        [`AOSCL_SEL_W-1:0]  sel;
		logic        [`AOSCL_GAIN_W-1:0] gain;
		logic signed [`AOSCL_BIAS_W-1:0] bias;
	} aoscl_chcfg_t;

	typedef struct packed {
		logic                     is_current;
		logic [`AOSCL_DAC_W-1:0]  code;
	} aoscl_ao_t;

	// ==========================================================
	// Code acceptance per control mode
	function automatic logic aoscl_code_ok(input logic [`AOSCL_SEL_W-1:0] c, input aoscl_mode_e m);
		logic vec;
		vec = (m == AOSCL_MODE_SLV) || (m == AOSCL_MODE_PM);
		if (c <= `AOSCL_SEL_W'(`AOSCL_CODE_BASIC_LAST)) begin
			aoscl_code_ok = 1'b1;
		end else if (c >= `AOSCL_SEL_W'(`AOSCL_CODE_PID_FIRST) && c <= `AOSCL_SEL_W'(`AOSCL_CODE_PID_LAST)) begin
			aoscl_code_ok = 1'b1;
		end else if (c >= `AOSCL_SEL_W'(`AOSCL_CODE_VEC_FIRST) && c <= `AOSCL_SEL_W'(`AOSCL_CODE_VEC_LAST)) begin
			aoscl_code_ok = vec;
		end else if (c == `AOSCL_SEL_W'(`AOSCL_CODE_VQ) || c == `AOSCL_SEL_W'(`AOSCL_CODE_VD)) begin
			aoscl_code_ok = vec;
		end else begin
			aoscl_code_ok = (c == `AOSCL_SEL_W'(`AOSCL_CODE_COMM));
		end
	endfunction

endpackage

/* rtl/aoscl_chan.sv */
// Purpose: Select one monitor quantity and apply gain and bias
// Assumes: Gain and bias in 0.1 percent steps
// Notes:   Refused codes give a zero quantity, so only the bias shows
`timescale 1ns/100ps
`include "aoscl_cfg.svh"
module aoscl_chan (
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	input  wire aoscl_pkg::aoscl_mon_t   mon_i,
	input  wire aoscl_pkg::aoscl_q_t     comm_i,
	input  wire aoscl_pkg::aoscl_mode_e  mode_i,
	input  wire aoscl_pkg::aoscl_chcfg_t cfg_i,
	output logic                       sel_ok_o,
	output aoscl_pkg::aoscl_y_t        y_o
);
	import aoscl_pkg::*;

	// ==========================================================
	// Selection, gain and bias
	aoscl_q_t           q;
	logic signed [30:0] prod;
	logic signed [47:0] scaled;
	logic signed [31:0] bterm;
	aoscl_y_t           y_nxt;
	logic               ok_nxt;

	always_comb begin
		ok_nxt = aoscl_code_ok(cfg_i.sel, mode_i);
		if (!ok_nxt) begin
			q = '0;
		end else if (cfg_i.sel == `AOSCL_SEL_W'(`AOSCL_CODE_COMM)) begin
			q = comm_i;
		end else begin
			q = mon_i[cfg_i.sel];
		end
		// Divide by 1000 through a reciprocal, avoiding a divider
		prod   = q * $signed({1'b0, cfg_i.gain});
		scaled = prod * $signed(`AOSCL_RECIP_W'(`AOSCL_RECIP));
		bterm  = cfg_i.bias * $signed(`AOSCL_RECIP_W'(`AOSCL_RECIP));
		y_nxt  = scaled[`AOSCL_RECIP_SH +: `AOSCL_Y_W] + bterm[`AOSCL_BIAS_SH +: `AOSCL_Y_W];
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			y_o      <= '0;
			sel_ok_o <= 1'b0;
		end else begin
			y_o      <= y_nxt;
			sel_ok_o <= ok_nxt;
		end
	end

endmodule // aoscl_chan

/* rtl/aoscl_filt.sv */
// Purpose: First-order output filter, saturation and converter code
// Assumes: tick_i pulses once per filter step
// Notes:   Time constant is ftime_i times sixteen steps
`timescale 1ns/100ps
`include "aoscl_cfg.svh"
module aoscl_filt (
	input  wire logic                      clk_i,
	input  wire logic                      resetn_i,
	input  wire logic                      tick_i,
	input  wire logic [`AOSCL_FILT_W-1:0]  ftime_i,
	input  wire logic                      is_current_i,
	input  wire aoscl_pkg::aoscl_y_t       x_i,
	output aoscl_pkg::aoscl_ao_t           ao_o
);
	import aoscl_pkg::*;

	localparam int ACC_W = `AOSCL_Y_W + `AOSCL_FILT_SH;

	// ==========================================================
	// Filter state
	logic signed [ACC_W-1:0]  acc_r, acc_nxt;
	logic signed [ACC_W:0]    diff;
	logic [`AOSCL_FILT_W-1:0] cnt_r, cnt_nxt;
	aoscl_y_t                 y;
	logic [`AOSCL_Q_FRAC:0]   ysat;
	logic [26:0]              span;
	aoscl_ao_t                ao_nxt;

	always_comb begin
		diff    = {x_i[`AOSCL_Y_W-1], x_i, `AOSCL_FILT_SH'(0)} - {acc_r[ACC_W-1], acc_r};
		acc_nxt = acc_r;
		cnt_nxt = cnt_r;
		if (ftime_i == '0) begin
			acc_nxt = {x_i, `AOSCL_FILT_SH'(0)};
			cnt_nxt = '0;
		end else if (tick_i) begin
			if (cnt_r >= ftime_i - 1'b1) begin
				cnt_nxt = '0;
				acc_nxt = acc_r + ACC_W'(diff >>> `AOSCL_FILT_SH);
			end else begin
				cnt_nxt = cnt_r + 1'b1;
			end
		end
		y = acc_r[ACC_W-1:`AOSCL_FILT_SH];
		// Saturate to 0..100 percent of the range
		if (y < 0) begin
			ysat = '0;
		end else if (y > `AOSCL_Y_W'(`AOSCL_Q_FULL)) begin
			ysat = (`AOSCL_Q_FRAC+1)'(`AOSCL_Q_FULL);
		end else begin
			ysat = y[`AOSCL_Q_FRAC:0];
		end
		ao_nxt.is_current = is_current_i;
		if (is_current_i) begin
			span        = ysat * 12'(`AOSCL_DAC_SPAN);
			ao_nxt.code = `AOSCL_DAC_W'(`AOSCL_DAC_LOW) + span[`AOSCL_Q_FRAC +: `AOSCL_DAC_W];
		end else begin
			span        = ysat * 12'(`AOSCL_DAC_TOP);
			ao_nxt.code = span[`AOSCL_Q_FRAC +: `AOSCL_DAC_W];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			acc_r <= '0;
			cnt_r <= '0;
			ao_o  <= '0;
		end else begin
			acc_r <= acc_nxt;
			cnt_r <= cnt_nxt;
			ao_o  <= ao_nxt;
		end
	end

endmodule // aoscl_filt

/* rtl/aoscl_top.sv */
// Purpose: Analog monitor output scaler with AHB-Lite register port
// Assumes: Single word transfers, monitor inputs synchronous to clk_i
// Notes:   Zero wait states, every response OKAY
`timescale 1ns/100ps
`include "aoscl_cfg.svh"
module aoscl_top #(
	parameter int STEP_CYC = `AOSCL_STEP_CYC
) (
	input  wire logic                       clk_i,
	input  wire logic                       resetn_i,
	input  wire logic                       hsel_i,
	input  wire logic [`AOSCL_ADDR_W-1:0]   haddr_i,
	input  wire logic [1:0]                 htrans_i,
	input  wire logic                       hwrite_i,
	input  wire logic [2:0]                 hsize_i,
	input  wire logic [31:0]                hwdata_i,
	input  wire logic                       hready_i,
	output logic                            hreadyout_o,
	output logic                            hresp_o,
	output logic [31:0]                     hrdata_o,
	input  wire aoscl_pkg::aoscl_mon_t      mon_i,
	input  wire aoscl_pkg::aoscl_mode_e     ctrl_mode_i,
	output aoscl_pkg::aoscl_ao_t            first_analog_output_o,
	output aoscl_pkg::aoscl_ao_t            second_analog_output_o
);
	import aoscl_pkg::*;

	generate
		if (STEP_CYC < 2) begin : g_bad_step
			$error("STEP_CYC must be at least 2");
		end
	endgenerate

	localparam int PRE_W = $clog2(STEP_CYC);

	// ==========================================================
	// Write clamping helpers
	function automatic logic [`AOSCL_GAIN_W-1:0] clamp_gain(input logic [31:0] w);
		if (w > 32'(`AOSCL_GAIN_MAX)) begin
			clamp_gain = `AOSCL_GAIN_W'(`AOSCL_GAIN_MAX);
		end else begin
			clamp_gain = w[`AOSCL_GAIN_W-1:0];
		end
	endfunction

	function automatic logic signed [`AOSCL_BIAS_W-1:0] clamp_bias(input logic [31:0] w);
		logic signed [31:0] s;
		s = $signed(w);
		if (s > 32'sd`AOSCL_BIAS_MAX) begin
			clamp_bias = `AOSCL_BIAS_W'(`AOSCL_BIAS_MAX);
		end else if (s < -32'sd`AOSCL_BIAS_MAX) begin
			clamp_bias = -`AOSCL_BIAS_W'(`AOSCL_BIAS_MAX);
		end else begin
			clamp_bias = s[`AOSCL_BIAS_W-1:0];
		end
	endfunction

	// ==========================================================
	// Bus phase tracking
	logic                      wen_r, wen_nxt;
	logic [`AOSCL_ADDR_W-1:0]  waddr_r, waddr_nxt;
	logic [31:0]               rdata_r, rdata_nxt;
	logic                      accept;

	// ==========================================================
	// Configuration registers
	aoscl_chcfg_t              ch_r [2];
	aoscl_chcfg_t              ch_nxt [2];
	logic [1:0]                type_r, type_nxt;
	logic [`AOSCL_FILT_W-1:0]  filt_r, filt_nxt;
	aoscl_q_t                  comm_r, comm_nxt;

	// ==========================================================
	// Datapath links
	aoscl_y_t                  y [2];
	logic [1:0]                sel_ok;
	aoscl_ao_t                 ao [2];
	logic [PRE_W-1:0]          pre_r, pre_nxt;
	logic                      tick_r, tick_nxt;

	assign accept      = hsel_i && htrans_i[1] && hready_i;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = `AOSCL_HRESP_OKAY;
	assign hrdata_o    = rdata_r;

	assign first_analog_output_o  = ao[0];
	assign second_analog_output_o = ao[1];

	// ==========================================================
	// Register writes in the data phase
	always_comb begin
		ch_nxt   = ch_r;
		type_nxt = type_r;
		filt_nxt = filt_r;
		comm_nxt = comm_r;
		if (wen_r) begin
			case (waddr_r)
				`AOSCL_OFF_SEL1: begin
					ch_nxt[0].sel = hwdata_i[`AOSCL_SEL_W-1:0];
				end
				`AOSCL_OFF_GAIN1: begin
					ch_nxt[0].gain = clamp_gain(hwdata_i);
				end
				`AOSCL_OFF_BIAS1: begin
					ch_nxt[0].bias = clamp_bias(hwdata_i);
				end
				`AOSCL_OFF_SEL2: begin
					ch_nxt[1].sel = hwdata_i[`AOSCL_SEL_W-1:0];
				end
				`AOSCL_OFF_GAIN2: begin
					ch_nxt[1].gain = clamp_gain(hwdata_i);
				end
				`AOSCL_OFF_BIAS2: begin
					ch_nxt[1].bias = clamp_bias(hwdata_i);
				end
				`AOSCL_OFF_TYPE: begin
					type_nxt = hwdata_i[1:0];
				end
				`AOSCL_OFF_FILT: begin
					// Longest setting caps the filter at half a second
					if (hwdata_i > 32'(`AOSCL_FILT_MAX)) begin
						filt_nxt = `AOSCL_FILT_W'(`AOSCL_FILT_MAX);
					end else begin
						filt_nxt = hwdata_i[`AOSCL_FILT_W-1:0];
					end
				end
				`AOSCL_OFF_COMM: begin
					comm_nxt = hwdata_i[`AOSCL_Q_W-1:0];
				end
				default: begin
					comm_nxt = comm_r;
				end
			endcase
		end
	end

	// ==========================================================
	// Address phase capture and read data
	always_comb begin
		wen_nxt   = accept && hwrite_i && (hsize_i == `AOSCL_HSIZE_WORD);
		waddr_nxt = accept ? haddr_i : waddr_r;
		rdata_nxt = rdata_r;
		if (accept && !hwrite_i) begin
			// Read from the next values so a write just before is seen
			rdata_nxt = '0;
			case (haddr_i)
				`AOSCL_OFF_SEL1: begin
					rdata_nxt = 32'(ch_nxt[0].sel);
				end
				`AOSCL_OFF_GAIN1: begin
					rdata_nxt = 32'(ch_nxt[0].gain);
				end
				`AOSCL_OFF_BIAS1: begin
					rdata_nxt = 32'(ch_nxt[0].bias);
				end
				`AOSCL_OFF_SEL2: begin
					rdata_nxt = 32'(ch_nxt[1].sel);
				end
				`AOSCL_OFF_GAIN2: begin
					rdata_nxt = 32'(ch_nxt[1].gain);
				end
				`AOSCL_OFF_BIAS2: begin
					rdata_nxt = 32'(ch_nxt[1].bias);
				end
				`AOSCL_OFF_TYPE: begin
					rdata_nxt = 32'(type_nxt);
				end
				`AOSCL_OFF_FILT: begin
					rdata_nxt = 32'(filt_nxt);
				end
				`AOSCL_OFF_COMM: begin
					rdata_nxt = 32'(comm_nxt);
				end
				`AOSCL_OFF_STAT: begin
					rdata_nxt[1:0] = ctrl_mode_i;
					rdata_nxt[`AOSCL_STAT_OK_LSB +: 2] = sel_ok;
				end
				`AOSCL_OFF_OUT1: begin
					rdata_nxt[`AOSCL_DAC_W-1:0]   = ao[0].code;
					rdata_nxt[`AOSCL_OUT_CUR_BIT] = ao[0].is_current;
				end
				`AOSCL_OFF_OUT2: begin
					rdata_nxt[`AOSCL_DAC_W-1:0]   = ao[1].code;
					rdata_nxt[`AOSCL_OUT_CUR_BIT] = ao[1].is_current;
				end
				default: begin
					rdata_nxt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			wen_r   <= 1'b0;
			waddr_r <= '0;
			rdata_r <= '0;
		end else begin
			wen_r   <= wen_nxt;
			waddr_r <= waddr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < 2; i++) begin
				ch_r[i].sel  <= '0;
				ch_r[i].gain <= `AOSCL_GAIN_W'(`AOSCL_GAIN_RST);
				ch_r[i].bias <= '0;
			end
			type_r <= '0;
			filt_r <= '0;
			comm_r <= '0;
		end else begin
			ch_r   <= ch_nxt;
			type_r <= type_nxt;
			filt_r <= filt_nxt;
			comm_r <= comm_nxt;
		end
	end

	// ==========================================================
	// Filter step divider
	always_comb begin
		tick_nxt = 1'b0;
		if (pre_r == PRE_W'(STEP_CYC - 1)) begin
			pre_nxt  = '0;
			tick_nxt = 1'b1;
		end else begin
			pre_nxt = pre_r + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pre_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			pre_r  <= pre_nxt;
			tick_r <= tick_nxt;
		end
	end

	// ==========================================================
	// Two output channels
	generate
		for (genvar g = 0; g < 2; g++) begin : g_ch
			aoscl_chan u_chan (
				.clk_i    (clk_i),
				.resetn_i (resetn_i),
				.mon_i    (mon_i),
				.comm_i   (comm_r),
				.mode_i   (ctrl_mode_i),
				.cfg_i    (ch_r[g]),
				.sel_ok_o (sel_ok[g]),
				.y_o      (y[g])
			);
			// Type bit 1 steers the first output, bit 0 the second
			aoscl_filt u_filt (
				.clk_i        (clk_i),
				.resetn_i     (resetn_i),
				.tick_i       (tick_r),
				.ftime_i      (filt_r),
				.is_current_i (type_r[1-g]),
				.x_i          (y[g]),
				.ao_o         (ao[g])
			);
		end
	endgenerate

endmodule // aoscl_top

/* sim/aoscl_properties.sv */
// Purpose: Port-level checks of the output scaler
// Assumes: One AHB-Lite master, gaps after config writes
// Notes:   Shadows follow SEL1 and TYPE as written on the bus
`timescale 1ns/100ps
`include "aoscl_cfg.svh"
module aoscl_properties
	import aoscl_pkg::*;
(
	input wire logic                  clk_i,
	input wire logic                  resetn_i,
	input wire logic                  hsel_i,
	input wire logic [7:0]            haddr_i,
	input wire logic [1:0]            htrans_i,
	input wire logic                  hwrite_i,
	input wire logic [2:0]            hsize_i,
	input wire logic [31:0]           hwdata_i,
	input wire logic                  hready_i,
	input wire logic                  hreadyout_o,
	input wire logic                  hresp_o,
	input wire logic [31:0]           hrdata_o,
	input wire aoscl_pkg::aoscl_mon_t  mon_i,
	input wire aoscl_pkg::aoscl_mode_e ctrl_mode_i,
	input wire aoscl_pkg::aoscl_ao_t   first_analog_output_o,
	input wire aoscl_pkg::aoscl_ao_t   second_analog_output_o
);
	// ==========================================================
	// Shadow registers
	logic       ap_r, ap_nxt;
	logic [7:0] ad_r, ad_nxt;
	logic [4:0] sel_r, sel_nxt;
	logic [1:0] typ_r, typ_nxt;
	wire        rd_w = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
	always_comb begin
		ap_nxt = hsel_i & htrans_i[1] & hready_i & hwrite_i & (hsize_i == `AOSCL_HSIZE_WORD);
		ad_nxt = haddr_i;
		sel_nxt = (ap_r && ad_r == `AOSCL_OFF_SEL1) ? hwdata_i[4:0] : sel_r;
		typ_nxt = (ap_r && ad_r == `AOSCL_OFF_TYPE) ? hwdata_i[1:0] : typ_r;
	end
	always_ff @(posedge clk_i) begin
		ap_r <= resetn_i & ap_nxt;
		ad_r <= ad_nxt;
		sel_r <= resetn_i ? sel_nxt : 5'h00;
		typ_r <= resetn_i ? typ_nxt : 2'h0;
	end
	function automatic logic okc(input logic [4:0] c, input logic [1:0] m);
		return c <= 9 || (c >= 21 && c <= 25) || c == 28 || ((m == 1 || m == 2) && (c inside {[10:13], 17, 18}));
	endfunction
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	a_ready_high: assert property (hreadyout_o == 1'b1) else $error("hreadyout low");
	a_resp_okay: assert property (hresp_o == `AOSCL_HRESP_OKAY) else $error("hresp not okay");
	a_reset_clear: assert property ($rose(resetn_i) |-> first_analog_output_o == '0
		&& second_analog_output_o == '0 && hrdata_o == 32'h0) else $error("outputs not cleared by reset");
	a_unmapped_zero: assert property (rd_w && haddr_i > `AOSCL_OFF_OUT2 |=> hrdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_stands: assert property ($past(resetn_i) && !$past(rd_w) |-> $stable(hrdata_o))
		else $error("read data moved");
	a_stat_mode: assert property (rd_w && haddr_i == `AOSCL_OFF_STAT && $stable(ctrl_mode_i)
		|=> hrdata_o[1:0] == $past(ctrl_mode_i)) else $error("status mode wrong");
	a_stat_accept: assert property (rd_w && haddr_i == `AOSCL_OFF_STAT && $stable(sel_r) && $stable(ctrl_mode_i)
		|=> hrdata_o[8] == okc($past(sel_r), $past(ctrl_mode_i))) else $error("status accept wrong");
	a_current_floor: assert property (first_analog_output_o.is_current |->
		first_analog_output_o.code >= `AOSCL_DAC_LOW) else $error("current code below floor");
	a_type_follow: assert property ($changed(typ_r) |-> ##[1:4] (first_analog_output_o.is_current == typ_r[1]
		&& second_analog_output_o.is_current == typ_r[0])) else $error("signal type not applied");
endmodule // aoscl_properties

bind aoscl_top aoscl_properties chk_u (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .mon_i(mon_i), .ctrl_mode_i(ctrl_mode_i),
	.first_analog_output_o(first_analog_output_o), .second_analog_output_o(second_analog_output_o));

/* sim/aoscl_meter.sv */
// Purpose: Meter on one analog output, in mV or uA
// Assumes: 12-bit converter code, 819 is the 4 mA floor
// Notes:   Integer reading, so a few units of error are normal
`timescale 1ns/100ps
module aoscl_meter (
	input  wire aoscl_pkg::aoscl_ao_t ao_i,
	output int                        level_o
);
	import aoscl_pkg::*;
	always_comb begin
		if (ao_i.is_current) begin
			level_o = 4000 + (int'(ao_i.code) - 819) * 16000 / 3276;
		end else begin
			level_o = int'(ao_i.code) * 10000 / 4095;
		end
	end
endmodule // aoscl_meter

/* sim/aoscl_tb_top.sv */
// Purpose: Self-checking bench of the output scaler
// Assumes: Filter step shortened to a few cycles
// Notes:   Meters read both outputs
`timescale 1ns/100ps
module aoscl_tb_top;
	import aoscl_pkg::*;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        hsel = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hrdy, hresp;
	logic [31:0] hrdata, d;
	aoscl_mon_t  mon = '0;
	aoscl_mode_e mode = AOSCL_MODE_VPH;
	aoscl_ao_t   ao1, ao2;
	int          lv1, lv2, f1, f2;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [7:0]  wa[13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h04, 8'h08, 8'h14, 8'h1c};
	int          wd[13] = '{3, 777, -5, 4, 888, 6, 2, 7, 'h1234, 20000, 2000, -2000, 63};
	int          we[13] = '{3, 777, -5, 4, 888, 6, 2, 7, 'h1234, 10000, 1000, -1000, 50};
	logic [7:0]  ta[19] = '{8'h1c, 8'h08, 8'h14, 8'h10, 8'h00, 8'h0c, 8'h04, 8'h18, 8'h18, 8'h0c, 8'h14, 8'h04,
		8'h08, 8'h04, 8'h08, 8'h20, 8'h04, 8'h00, 8'h20};
	int          tv[19] = '{0, 0, 0, 1000, 0, 5, 1000, 0, 3, 6, 500, 500, -1000, 10000, 0, 'h4000, 1000, 28, 0};
	int          e1[19] = '{-1, -1, -1, -1, -1, -1, 4095, 4095, 4095, 4095, 4095, 2457, 819, 4095, 4095, 4095,
		4095, 4095, 819};
	int          e2[19] = '{-1, -1, -1, -1, -1, -1, 2047, 2047, 2457, 819, 2457, 2457, 2457, 2457, 2457, 2457,
		2457, 2457, 2457};

	aoscl_top #(.STEP_CYC(4)) dut_u (.clk_i(clk), .resetn_i(resetn), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
		.hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .mon_i(mon), .ctrl_mode_i(mode),
		.first_analog_output_o(ao1), .second_analog_output_o(ao2));
	aoscl_meter m1_u (.ao_i(ao1), .level_o(lv1));
	aoscl_meter m2_u (.ao_i(ao2), .level_o(lv2));

	always #2.5 clk = ~clk;
	// Ceiling well above the roughly 4300 cycles of the tests
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	// ==========================================================
	// Tasks
	task automatic bus(input logic [7:0] a, input logic w, input logic [2:0] sz, input logic [31:0] v,
		output logic [31:0] r);
		hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= sz;
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= v;
		do @(posedge clk); while (hrdy !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] r;
		bus(a, 1'b1, 3'h2, v, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(a, 1'b0, 3'h2, 32'h0, r);
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input int t = 0);
		cmp_count++;
		if ((^g) === 1'bx || (g > e ? g - e : e - g) > t) begin
			n_fail++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask
	function automatic logic okc(int c, int m);
		return c <= 9 || (c >= 21 && c <= 25) || c == 28 || ((m == 1 || m == 2) && (c inside {[10:13], 17, 18}));
	endfunction
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 9; i++) begin
			rd(wa[i], d);
			cmp(d, i == 1 || i == 4 ? 1000 : 0);
		end
		rd(8'h30, d);
		cmp(d, 0);
		for (int i = 0; i < 13; i++) begin
			wr(wa[i], wd[i]);
			rd(wa[i], d);
			cmp(d, we[i]);
		end
		$display("end of test registers");
		mon[0] <= 16'h4000;
		mon[5] <= 16'h2000;
		for (int i = 0; i < 19; i++) begin
			wr(ta[i], tv[i]);
			repeat (4) @(posedge clk);
			if (e1[i] >= 0) begin
				cmp(ao1.code, e1[i], 2);
				cmp(ao2.code, e2[i], 2);
			end
		end
		wr(8'h20, 32'h4000);
		repeat (4) @(posedge clk);
		cmp(lv1, 20000, 5);
		cmp(lv2, 12000, 10);
		rd(8'h28, d);
		cmp(d, 32'h10fff, 2);
		$display("end of test scaling");
		mon[10] <= 16'h4000;
		for (int m = 0; m < 4; m++) begin
			mode <= aoscl_mode_e'(m);
			repeat (2) @(posedge clk);
			for (int c = 0; c < 32; c++) begin
				wr(8'h00, c);
				wr(8'h0c, c);
				@(posedge clk);
				rd(8'h24, d);
				cmp(d[8], okc(c, m));
				cmp(d[9], okc(c, m));
				cmp(d[1:0], m);
			end
			wr(8'h00, 10);
			repeat (4) @(posedge clk);
			cmp(ao1.code, m == 1 || m == 2 ? 4095 : 819, 2);
		end
		$display("end of test codes");
		wr(8'h00, 0);
		for (int k = 1; k <= 2; k++) begin
			mon[0] <= 16'h0000;
			wr(8'h1c, 0);
			repeat (4) @(posedge clk);
			wr(8'h1c, k);
			mon[0] <= 16'h4000;
			repeat (64) @(posedge clk);
			if (k == 1) f1 = ao1.code; else f2 = ao1.code;
		end
		cmp(f1 > f2, 1);
		cmp(f1 < 4000 && f2 > 900, 1);
		repeat (3000) @(posedge clk);
		cmp(ao1.code, 4095, 8);
		$display("end of test filter");
		// Byte write must not touch the gain
		bus(8'h04, 1'b1, 3'h0, 32'h5, d);
		rd(8'h04, d);
		cmp(d, 1000);
		wr(8'h04, 222);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(8'h04, d);
		cmp(d, 1000);
		$display("end of test reset");
		results();
	end
endmodule // aoscl_tb_top
